/* File: isv_vectoring.sv */
// Purpose: Per-source control registers, request arbitration and trap vectoring
// Assumes: Request and trap events are one-cycle pulses on clk_i
// Notes:   Vector address is trap number times four; traps override requests
`timescale 1ns/1ns
`default_nettype none
`include "isv_consts.svh"
// Function
// - Fixed trap number, vector equals four times it
// - Hardware traps are immediate and non-maskable
// - Hardware trap sets its trap flag bit
// - Trap preempts unless same or higher class trap active
// - Trap service blocks standard interrupt requests
// - Every source has identically laid out register
// - Status in low byte, high byte reserved
// - Single-bit access, all bits read/write
// - Word access: bits 15..8 read zero
// - Bits 5..2 priority level, Fh highest
// - Bits 1..0 group level, 3 highest
// - Bit 6 enables the source
// - Bit 7 flags a pending request
module isv_vectoring (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [55:0] src_evt_i,
  input  wire logic [3:0]  cpu_priority_level_field_i,
  input  wire logic        irq_ack_i,
  input  wire logic [7:0]  hw_trap_i,
  input  wire logic        trap_ack_i,
  input  wire logic        trap_done_i,
  output logic             irq_req_o,
  output logic      [5:0]  irq_src_o,
  output logic      [6:0]  irq_trap_o,
  output logic      [8:0]  irq_vec_o,
  output logic             trap_req_o,
  output logic      [6:0]  trap_num_o,
  output logic      [8:0]  trap_vec_o
);
  localparam int N  = `ISV_NUM_SRC;
  localparam int IW = 6;
  localparam logic [6:0] TRAP_NUM [N] = `ISV_TRAP_NUMS;

  logic [7:0]            ctl [N];
  logic [8*N-1:0]        ctl_flat;
  logic [7:0]            trap_flag_register;
  logic [7:0]            trap_pend;
  logic [7:0]            trap_mask;
  isv_pkg::isv_trap_cls_t trap_cls;
  isv_pkg::isv_trap_cls_t trap_req_cls;
  isv_pkg::isv_trap_cls_t next_cls;
  logic [7:0]            next_mask;
  logic [6:0]            next_num;
  logic                  win_valid;
  logic [IW-1:0]         win_idx;
  logic [3:0]            win_priority_level_field;
  logic                  bus_req;
  logic                  wr_take;
  logic                  in_src;
  logic [IW-1:0]         reg_idx;
  logic                  bop_ok;
  logic [31:0]           rd_data;

  // Bus decode; writes commit on the edge at which the master sees ack
  assign bus_req = cyc_i & stb_i;
  assign wr_take = bus_req & we_i & ack_o;
  assign reg_idx = adr_i[7:2];
  assign in_src  = (adr_i[9:8] == 2'b00) && (reg_idx < IW'(N));
  assign bop_ok  = dat_i[`ISV_BOP_IDX_HI:0] < IW'(N);

  // One control register per source, all with the same layout
  for (genvar i = 0; i < N; i++) begin : g_src
    assign ctl_flat[8*i +: 8] = ctl[i];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctl[i] <= `ISV_CTL_RST;
      end else begin
        if (wr_take && in_src && reg_idx == IW'(i) && sel_i[0]) begin
          ctl[i] <= dat_i[7:0];
        end
        if (wr_take && adr_i == `ISV_BITOP_ADDR && bop_ok
            && dat_i[`ISV_BOP_IDX_HI:0] == IW'(i)) begin
          ctl[i][dat_i[`ISV_BOP_BIT_HI:`ISV_BOP_BIT_LO]] <= dat_i[`ISV_BOP_VAL];
        end
        if (irq_ack_i && irq_req_o && irq_src_o == IW'(i)) begin
          ctl[i][`ISV_IR_BIT] <= 1'b0;
        end
        // A new request wins over a clear in the same cycle
        if (src_evt_i[i]) begin
          ctl[i][`ISV_IR_BIT] <= 1'b1;
        end
      end
    end
  end

  isv_arbiter #(
    .N  (N),
    .IW (IW)
  ) u_arb (
    .ctl_i       (ctl_flat),
    .win_valid_o (win_valid),
    .win_idx_o   (win_idx),
    .win_priority_level_field_o  (win_priority_level_field)
  );

  // Read mux; source and trap flag registers read zero above bit 7, the status register above bit 17
  always_comb begin
    rd_data = 32'h0000_0000;
    if (in_src) begin
      rd_data[7:0] = ctl[reg_idx];
    end else if (adr_i == `ISV_TFR_ADDR) begin
      rd_data[7:0] = trap_flag_register;
    end else if (adr_i == `ISV_STAT_ADDR) begin
      rd_data = {14'h0000, trap_cls, trap_req_o, irq_req_o, irq_src_o, win_valid, irq_trap_o};
    end
  end

  // Classic single-cycle slave: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req & ~ack_o;
      if (bus_req && !ack_o) begin
        dat_o <= rd_data;
      end
    end
  end

  // Trap flags: set by the trap, cleared by writing one; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_flag_register <= `ISV_TFR_RST;
    end else begin
      trap_flag_register <= (trap_flag_register & ~((wr_take && adr_i == `ISV_TFR_ADDR && sel_i[0]) ? dat_i[7:0] : 8'h00))
             | hw_trap_i;
    end
  end

  // Pick the most urgent pending trap; class B traps share one vector
  always_comb begin
    next_cls  = isv_pkg::ISV_CLS_NONE;
    next_mask = 8'h00;
    next_num  = `ISV_TRAP_B;
    if (trap_pend[0]) begin
      next_cls  = isv_pkg::ISV_CLS_A;
      next_mask = 8'h01;
      next_num  = `ISV_TRAP_A0;
    end else if (trap_pend[1]) begin
      next_cls  = isv_pkg::ISV_CLS_A;
      next_mask = 8'h02;
      next_num  = `ISV_TRAP_A1;
    end else if (trap_pend[2]) begin
      next_cls  = isv_pkg::ISV_CLS_A;
      next_mask = 8'h04;
      next_num  = `ISV_TRAP_A2;
    end else if (|trap_pend[7:`ISV_CLSB_LO]) begin
      next_cls  = isv_pkg::ISV_CLS_B;
      next_mask = 8'hF8;
    end
  end

  // Pending traps; no mask exists, a taken trap only clears its own bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_pend <= 8'h00;
    end else begin
      trap_pend <= (trap_pend & ~((trap_ack_i && trap_req_o) ? trap_mask : 8'h00))
                   | hw_trap_i;
    end
  end

  // Trap presentation: only a higher class than the active one gets through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_req_o   <= 1'b0;
      trap_num_o   <= 7'h00;
      trap_vec_o   <= 9'h000;
      trap_mask    <= 8'h00;
      trap_req_cls <= isv_pkg::ISV_CLS_NONE;
    end else begin
      trap_req_o   <= (next_cls > trap_cls) && !trap_ack_i;
      trap_num_o   <= next_num;
      trap_vec_o   <= {next_num, 2'b00};
      trap_mask    <= next_mask;
      trap_req_cls <= next_cls;
    end
  end

  // Active trap service class; a single level, done returns to normal code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_cls <= isv_pkg::ISV_CLS_NONE;
    end else if (trap_ack_i && trap_req_o) begin
      trap_cls <= trap_req_cls;
    end else if (trap_done_i) begin
      trap_cls <= isv_pkg::ISV_CLS_NONE;
    end
  end

  // Standard request: above CPU level, and never during or ahead of a trap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o  <= 1'b0;
      irq_src_o  <= 6'h00;
      irq_trap_o <= 7'h00;
      irq_vec_o  <= 9'h000;
    end else begin
      irq_req_o  <= win_valid && (win_priority_level_field > cpu_priority_level_field_i) && !irq_ack_i
                    && trap_cls == isv_pkg::ISV_CLS_NONE && trap_pend == 8'h00;
      irq_src_o  <= win_idx;
      irq_trap_o <= TRAP_NUM[win_idx];
      irq_vec_o  <= {TRAP_NUM[win_idx], 2'b00};
    end
  end

  // Checks
  sequence s_trap_seen;
    (|hw_trap_i) && trap_cls == isv_pkg::ISV_CLS_NONE && !trap_ack_i;
  endsequence
  sequence s_no_take;
    !trap_ack_i;
  endsequence

  a_vec_times_four: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o |-> irq_vec_o == {irq_trap_o, 2'b00})
    else $error("vector is not four times the trap number");
  a_trap_num_map: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o |-> irq_trap_o == TRAP_NUM[irq_src_o])
    else $error("trap number does not match source");
  a_trap_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (|hw_trap_i) |=> (trap_flag_register & $past(hw_trap_i)) == $past(hw_trap_i))
    else $error("trap flag not set");
  a_trap_presented: assert property (@(posedge clk_i) disable iff (rst_i)
    s_trap_seen ##1 s_no_take |-> ##1 trap_req_o)
    else $error("hardware trap not presented");
  a_trap_no_preempt: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_cls == isv_pkg::ISV_CLS_A |-> !trap_req_o)
    else $error("trap presented during class A service");
  a_trap_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_cls != isv_pkg::ISV_CLS_NONE |-> !irq_req_o)
    else $error("interrupt request during trap service");
  a_high_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !ack_o && !we_i && in_src) |=> dat_o[31:8] == 24'h000000)
    else $error("reserved bits read non-zero");
  a_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !win_valid |=> !irq_req_o)
    else $error("request without enabled pending source");
  a_level_above_cpu: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_req_o |-> $past(win_priority_level_field) > $past(cpu_priority_level_field_i))
    else $error("request not above CPU level");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    src_evt_i[0] |=> ctl[0][`ISV_IR_BIT])
    else $error("request flag lost");
endmodule : isv_vectoring
`default_nettype wire

/* File: isv_consts.svh */
// Purpose: Constants for the interrupt source vectoring block
// Assumes: Included by bare name from the block's design files
// Notes:   Byte addresses on a 32-bit Wishbone bus, one register per word
`ifndef ISV_CONSTS_SVH
`define ISV_CONSTS_SVH

// Register map (byte addresses)
`define ISV_ADR_W        10
`define ISV_SRC_BASE     10'h000
`define ISV_TFR_ADDR     10'h100
`define ISV_BITOP_ADDR   10'h104
`define ISV_STAT_ADDR    10'h108

// Source control register layout
`define ISV_CTL_RST      8'h00
`define ISV_IR_BIT       7
`define ISV_IE_BIT       6
`define ISV_KEY_HI       5
`define ISV_PRIORITY_LEVEL_FIELD_HI      5
`define ISV_PRIORITY_LEVEL_FIELD_LO      2
`define ISV_GROUP_ORDER_FIELD_HI      1
`define ISV_GROUP_ORDER_FIELD_LO      0

// Bit-modify register fields
`define ISV_BOP_IDX_HI   5
`define ISV_BOP_BIT_HI   8
`define ISV_BOP_BIT_LO   6
`define ISV_BOP_VAL      9

// Trap flag register layout: class A in [2:0], class B in [7:3]
`define ISV_TFR_RST      8'h00
`define ISV_CLSA_HI      2
`define ISV_CLSB_LO      3

// Hardware trap numbers
`define ISV_TRAP_A0      7'h02
`define ISV_TRAP_A1      7'h04
`define ISV_TRAP_A2      7'h06
`define ISV_TRAP_B       7'h0A

// Trap numbers of the 56 request sources, in source index order
`define ISV_NUM_SRC      56
`define ISV_TRAP_NUMS '{ \
  7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, \
  7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F, \
  7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37, \
  7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h44, 7'h45, 7'h46, \
  7'h20, 7'h21, 7'h3D, 7'h3E, 7'h22, 7'h23, 7'h24, 7'h25, \
  7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C, \
  7'h2D, 7'h2E, 7'h2F, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43 }

`endif

/* File: isv_pkg.sv */
// Purpose: Types for the interrupt source vectoring block
// Assumes: Nothing beyond the consts header
// Notes:   Trap classes are ordered so that a larger value preempts
`default_nettype none
package isv_pkg;
  typedef enum logic [1:0] {
    ISV_CLS_NONE,
    ISV_CLS_B,
    ISV_CLS_A
  } isv_trap_cls_t;
endpackage : isv_pkg
`default_nettype wire

/* File: isv_arbiter.sv */
// Purpose: Picks the winning request by priority level, then group level
// Assumes: Control bytes packed eight bits per source
// Notes:   Purely combinational; on a full tie the lowest index wins
`timescale 1ns/1ns
`default_nettype none
`include "isv_consts.svh"
module isv_arbiter #(
  parameter int N  = 56,
  parameter int IW = 6
) (
  input  wire logic [8*N-1:0] ctl_i,
  output logic                win_valid_o,
  output logic [IW-1:0]       win_idx_o,
  output logic [3:0]          win_priority_level_field_o
);
  logic [N:0]    chain_v;
  logic [5:0]    chain_key [N+1];
  logic [IW-1:0] chain_idx [N+1];

  assign chain_v[0]   = 1'b0;
  assign chain_key[0] = 6'h00;
  assign chain_idx[0] = '0;

  // Linear chain; strict compare keeps the earlier entry on ties
  for (genvar i = 0; i < N; i++) begin : g_chain
    logic       cand;
    logic [5:0] key;
    logic       better;
    assign cand   = ctl_i[8*i+`ISV_IR_BIT] & ctl_i[8*i+`ISV_IE_BIT];
    assign key    = ctl_i[8*i +: 6];
    assign better = cand && (!chain_v[i] || key > chain_key[i]);
    assign chain_v[i+1]   = chain_v[i] | cand;
    assign chain_key[i+1] = better ? key : chain_key[i];
    assign chain_idx[i+1] = better ? IW'(i) : chain_idx[i];
  end

  assign win_valid_o = chain_v[N];
  assign win_idx_o   = chain_idx[N];
  assign win_priority_level_field_o  = chain_key[N][`ISV_PRIORITY_LEVEL_FIELD_HI:`ISV_PRIORITY_LEVEL_FIELD_LO];
endmodule : isv_arbiter
`default_nettype wire

/* File: isv_cpu_model.sv */
// Purpose: CPU core stand-in that takes interrupt and trap vectors
// Assumes: Shares clk_i with the block; acks are one-cycle pulses
// Notes:   hold_i stalls interrupt acceptance to model a slow core
`timescale 1ns/1ns
`default_nettype none
module isv_cpu_model #(
  parameter int DONE_CYC = 40
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       hold_i,
  input  wire logic       irq_req_i,
  input  wire logic [8:0] irq_vec_i,
  input  wire logic       trap_req_i,
  input  wire logic [8:0] trap_vec_i,
  output logic            irq_ack_o,
  output logic            trap_ack_o,
  output logic            trap_done_o,
  output logic      [7:0] irq_cnt_o,
  output logic      [8:0] irq_got_o,
  output logic      [7:0] trap_cnt_o,
  output logic      [8:0] trap_got_o
);
  int left;
  // Interrupts: one ack per request, so a held request is never taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ack_o <= 1'b0;
      irq_cnt_o <= 8'h00;
      irq_got_o <= 9'h000;
    end else begin
      irq_ack_o <= irq_req_i && !irq_ack_o && !hold_i;
      if (irq_ack_o && irq_req_i) begin
        irq_cnt_o <= irq_cnt_o + 8'h01;
        irq_got_o <= irq_vec_i;
      end
    end
  end
  // Traps: ack at once, return DONE_CYC cycles after the last ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_ack_o  <= 1'b0;
      trap_done_o <= 1'b0;
      trap_cnt_o  <= 8'h00;
      trap_got_o  <= 9'h000;
      left        <= 0;
    end else begin
      trap_ack_o  <= trap_req_i && !trap_ack_o;
      trap_done_o <= (left == 1);
      if (trap_ack_o && trap_req_i) begin
        trap_cnt_o <= trap_cnt_o + 8'h01;
        trap_got_o <= trap_vec_i;
        left       <= DONE_CYC;
      end else if (left != 0) begin
        left <= left - 1;
      end
    end
  end
endmodule : isv_cpu_model
`default_nettype wire

/* File: tb_isv_vectoring.sv */
// Purpose: Self-checking bench for the interrupt source vectoring block
// Assumes: Register access over classic Wishbone, CPU model on the far side
// Notes:   Expected vectors in t_vec come from the bench's own trap number table; the other tests use literal vectors
`timescale 1ns/1ns
`default_nettype none
module tb_isv_vectoring;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, hold;
  logic        irq_ack, trap_ack, trap_done, irq_req, trap_req;
  logic [9:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i, cpu_priority_level_field_i;
  logic [55:0] src_evt_i;
  logic [7:0]  hw_trap_i, irq_cnt, trap_cnt;
  logic [5:0]  irq_src;
  logic [6:0]  irq_trap, trap_num;
  logic [8:0]  irq_vec, trap_vec, irq_got, trap_got;
  int          error_cnt, n_tests, cycles;
  int          idx [10] = '{0, 15, 16, 28, 29, 31, 32, 45, 51, 55};
  logic [6:0]  tno [10] = '{7'h10, 7'h1F, 7'h30, 7'h3C, 7'h44, 7'h46, 7'h20, 7'h47, 7'h3F, 7'h43};

  isv_vectoring i_isv_vectoring (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .src_evt_i(src_evt_i), .cpu_priority_level_field_i(cpu_priority_level_field_i), .irq_ack_i(irq_ack), .hw_trap_i(hw_trap_i),
    .trap_ack_i(trap_ack), .trap_done_i(trap_done), .irq_req_o(irq_req), .irq_src_o(irq_src),
    .irq_trap_o(irq_trap), .irq_vec_o(irq_vec), .trap_req_o(trap_req),
    .trap_num_o(trap_num), .trap_vec_o(trap_vec));
  isv_cpu_model i_isv_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
    .irq_req_i(irq_req), .irq_vec_i(irq_vec), .trap_req_i(trap_req), .trap_vec_i(trap_vec),
    .irq_ack_o(irq_ack), .trap_ack_o(trap_ack), .trap_done_o(trap_done), .irq_cnt_o(irq_cnt),
    .irq_got_o(irq_got), .trap_cnt_o(trap_cnt), .trap_got_o(trap_got));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    n = 0;
    // Ends on ack; if ack never comes, only the bench's hang guard ends this wait
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    r = dat_o;
    chk("bus ack latency", 32'h0000_0002, n);
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hF, r);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, 4'hF, r);
    chk("register read", e, r);
  endtask : rdc
  task automatic evt(input logic [55:0] m);
    @(posedge clk_i);
    src_evt_i <= m;
    @(posedge clk_i);
    src_evt_i <= 56'h0;
  endtask : evt
  // Waits for the CPU model to take a vector, then compares it
  task automatic take(input bit t, input logic [8:0] e);
    logic [7:0] c;
    int n;
    c = t ? trap_cnt : irq_cnt;
    n = 0;
    while ((t ? trap_cnt : irq_cnt) === c && n < 150) begin
      @(posedge clk_i);
      n++;
    end
    chk(t ? "trap vector" : "irq vector", {23'h0, e}, {23'h0, t ? trap_got : irq_got});
  endtask : take

  task automatic t_regs();
    rdc(10'h000, 32'h0);
    rdc(10'h100, 32'h0);
    wr(10'h008, 32'hFFFF_FF3D);
    rdc(10'h008, 32'h0000_003D);
    wr(10'h0DC, 32'h0000_00BD);
    rdc(10'h0DC, 32'h0000_00BD);
    wr(10'h0DC, 32'h0);
    wr(10'h104, 32'h0000_0385);
    rdc(10'h014, 32'h0000_0040);
    wr(10'h104, 32'h0000_0185);
    rdc(10'h014, 32'h0000_0000);
  endtask : t_regs
  task automatic t_vec();
    for (int i = 0; i < 10; i++) begin
      wr(10'(4 * idx[i]), 32'h44);
      evt(56'h1 << idx[i]);
      take(1'b0, {tno[i], 2'b00});
      rdc(10'(4 * idx[i]), 32'h44);
      wr(10'(4 * idx[i]), 32'h0);
    end
  endtask : t_vec
  // Equal level at the CPU is refused; level beats group, disabled never wins
  task automatic t_arb();
    cpu_priority_level_field_i <= 4'h6;
    hold <= 1'b1;
    wr(10'h004, 32'h54);
    wr(10'h008, 32'h57);
    wr(10'h00C, 32'h24);
    wr(10'h010, 32'h58);
    evt(56'h1E);
    repeat (4) @(posedge clk_i);
    chk("irq level gate", 32'h0, {31'h0, irq_req});
    cpu_priority_level_field_i <= 4'h0;
    rdc(10'h108, 32'h0000_4494);
    hold <= 1'b0;
    take(1'b0, 9'h050);
    take(1'b0, 9'h048);
    take(1'b0, 9'h044);
    rdc(10'h00C, 32'h0000_00A4);
    for (int i = 1; i < 5; i++) wr(10'(4 * i), 32'h0);
  endtask : t_arb
  task automatic t_trap();
    wr(10'h000, 32'h7C);
    @(posedge clk_i);
    hw_trap_i <= 8'h80;
    @(posedge clk_i);
    hw_trap_i <= 8'h00;
    take(1'b1, 9'h028);
    evt(56'h1);
    repeat (3) @(posedge clk_i);
    chk("irq during trap", 32'h0, {31'h0, irq_req});
    hw_trap_i <= 8'h01;
    @(posedge clk_i);
    hw_trap_i <= 8'h00;
    // Request and number stand from the second edge after the trap
    repeat (2) @(posedge clk_i);
    chk("trap request and number", 32'h0000_0082, {24'h0, trap_req, trap_num});
    take(1'b1, 9'h008);
    rdc(10'h100, 32'h0000_0081);
    take(1'b0, 9'h040);
    wr(10'h100, 32'h0000_00FF);
    rdc(10'h100, 32'h0);
    wr(10'h000, 32'h0);
  endtask : t_trap

  initial begin
    {rst_i, hold} = 2'b10;
    {we_i, cyc_i, stb_i, adr_i, dat_i, sel_i} = '0;
    {src_evt_i, cpu_priority_level_field_i, hw_trap_i} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_vec();
    t_arb();
    t_trap();
    conclude();
  end
endmodule : tb_isv_vectoring
`default_nettype wire
